// ===== rotate_subtract_skip_exec_tb_top.sv
// Self-checking testbench for the execution datapath
`timescale 1ns/1ps
`default_nettype none
`include "rsx_cfg.svh"

module rotate_subtract_skip_exec_tb_top;
    import rsx_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn;
    logic        req_valid, req_ready, irq_pending, stack_pop, irq_enter, skip_next;
    exec_req_s   req;
    mem_wr_s     mem_wr;
    byte_t       working_register;
    flags_s      flags;
    logic        global_irq_enable;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int          n_errors = 0;
    int          checks = 0;
    logic [31:0] seed;
    byte_t       e_w = 8'h00, e_md = 8'h00, e_cnt = 8'h00;
    flags_s      e_f = '0;
    logic        e_gie = 1'b0, e_mwe, e_skip, e_pop, e_irq;

    always #5 aclk = ~aclk;

    rsx_exec u_rsx_exec (.aclk, .aresetn, .req_valid, .req, .req_ready, .irq_pending,
        .stack_pop, .irq_enter, .skip_next, .mem_wr, .working_register, .flags,
        .global_irq_enable, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    seq_model u_seq_model (.aclk, .req, .req_valid, .req_ready, .irq_pending);

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic alu_s sub(byte_t a, byte_t b, logic bin);
        logic [8:0] d;
        logic [4:0] l;
        d = {1'b0, a} - {1'b0, b} - 9'(bin);
        l = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(bin);
        return '{res: d[7:0], f: '{ov: (a[7] != b[7]) && (d[7] != a[7]),
                 z: d[7:0] == 8'h00, ac: !l[4], c: !d[8]}};
    endfunction

    function automatic void predict(exec_req_s r, logic irq);
        alu_s  s;
        logic  to_w;
        logic  to_m;
        byte_t m;
        m = r.mem;
        s = '{res: m, f: e_f};
        {e_skip, e_pop, e_irq} = 3'b000;
        case (r.op)
            call_exit_load_literal: {e_pop, s.res} = {1'b1, r.imm};
            interrupt_exit: {e_pop, e_gie, e_irq} = {2'b11, irq};
            rotate_left_mem, rotate_left_to_working: s.res = {m[6:0], m[7]};
            rotate_left_through_carry,
            rotate_left_through_carry_to_working: {s.f.c, s.res} = {m, e_f.c};
            rotate_right_mem, rotate_right_to_working: s.res = {m[0], m[7:1]};
            rotate_right_through_carry,
            rotate_right_through_carry_to_working: {s.res, s.f.c} = {e_f.c, m};
            minus_to_working, minus_to_mem: s = sub(e_w, m, 1'b0);
            minus_literal: s = sub(e_w, r.imm, 1'b0);
            minus_with_borrow_to_working,
            minus_with_borrow_to_mem: s = sub(e_w, m, !e_f.c);
            decrement_skip_zero, decrement_skip_zero_to_working: s.res = m - 8'h01;
            increment_skip_zero, increment_skip_zero_to_working: s.res = m + 8'h01;
            fill_byte: s.res = 8'hff;
            bit_force: s.res = m | (8'h01 << r.bit_sel);
            skip_bit_nonzero: e_skip = m[r.bit_sel];
            default: e_skip = 1'b0;
        endcase
        to_w = r.op inside {call_exit_load_literal, rotate_left_to_working, minus_literal,
            rotate_left_through_carry_to_working, rotate_right_to_working, minus_to_working,
            rotate_right_through_carry_to_working, minus_with_borrow_to_working,
            decrement_skip_zero_to_working, increment_skip_zero_to_working};
        to_m = r.op inside {rotate_left_mem, rotate_left_through_carry, rotate_right_mem,
            rotate_right_through_carry, minus_to_mem, minus_with_borrow_to_mem, bit_force,
            decrement_skip_zero, increment_skip_zero, fill_byte};
        if (r.op inside {decrement_skip_zero, decrement_skip_zero_to_working,
            increment_skip_zero, increment_skip_zero_to_working}) e_skip = s.res == 8'h00;
        if (to_w) e_w = s.res;
        e_md = to_m ? s.res : m;
        e_mwe = to_m;
        e_f   = s.f;
        e_cnt = e_cnt + 8'(e_skip);
    endfunction

    task automatic wrap_up();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic cmp(string name, logic [39:0] e, logic [39:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic axi_wr(logic [11:0] a, logic [31:0] d, logic [1:0] er);
        logic ok;
        @(posedge aclk);
        ok = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        s_axi_awaddr <= a;
        s_axi_wdata  <= d;
        for (int i = 0; i < 20 && !ok; i++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            ok = s_axi_bvalid;
        end
        s_axi_bready <= 1'b0;
        cmp("bresp", {ok, er}, {1'b1, s_axi_bresp});
        if (!ok) wrap_up();
    endtask

    task automatic axi_rd(logic [11:0] a, logic [31:0] ed, logic [1:0] er);
        logic ok;
        @(posedge aclk);
        ok = 1'b0;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        s_axi_araddr <= a;
        for (int i = 0; i < 20 && !ok; i++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            ok = s_axi_rvalid;
        end
        s_axi_rready <= 1'b0;
        cmp("rdata", {ok, er, ed}, {1'b1, s_axi_rresp, s_axi_rdata});
        if (!ok) wrap_up();
    endtask

    task automatic run_op(exec_req_s r, logic irq);
        logic ok;
        predict(r, irq);
        u_seq_model.issue(r, irq, ok);
        cmp("taken", 1, ok);
        if (!ok) wrap_up();
        // Sampled at the next edge, so the one-cycle pulses are still standing
        @(posedge aclk);
        cmp("working", e_w, working_register);
        cmp("flags", e_f, flags);
        cmp("mem_wr", {e_mwe, e_md}, mem_wr);
        cmp("pulses", {e_skip, e_pop, e_irq, e_gie, !e_skip},
            {skip_next, stack_pop, irq_enter, global_irq_enable, req_ready});
    endtask

    initial begin
        exec_req_s   r;
        logic [31:0] v;
        seed = 32'ha40e;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(`RSX_OFF_CTRL, `RSX_CTRL_RESET, `RSX_RESP_OKAY);
        axi_rd(`RSX_OFF_FLAGS, 32'h0, `RSX_RESP_OKAY);
        axi_rd(12'h010, 32'h0, `RSX_RESP_DECERR);
        axi_wr(12'h010, rnd(), `RSX_RESP_DECERR);
        v = rnd();
        axi_wr(`RSX_OFF_WORK, v, `RSX_RESP_OKAY);
        axi_wr(`RSX_OFF_FLAGS, v >> 8, `RSX_RESP_OKAY);
        {e_w, e_gie, e_f} = {v[7:0], v[12:8]};
        axi_rd(`RSX_OFF_WORK, {24'h0, e_w}, `RSX_RESP_OKAY);
        axi_rd(`RSX_OFF_FLAGS, {27'h0, e_gie, e_f}, `RSX_RESP_OKAY);
        axi_wr(`RSX_OFF_CTRL, 32'h0, `RSX_RESP_OKAY);
        @(posedge aclk);
        cmp("ready_off", 1'b0, req_ready);
        axi_wr(`RSX_OFF_CTRL, `RSX_CTRL_RESET, `RSX_RESP_OKAY);
        $display("test registers done");
        // Two corner passes over every operation, then random traffic
        for (int i = 0; i < 120; i++) begin
            v = rnd();
            r.op = exec_op_e'(i < 44 ? i % 22 + 1 : v[31:24] % 22 + 1);
            r.mem = i < 22 ? 8'h01 : i < 44 ? 8'hff : v[7:0];
            r.imm = v[15:8];
            r.bit_sel = v[18:16];
            run_op(r, v[19]);
        end
        $display("test operations done");
        axi_rd(`RSX_OFF_STAT, {16'h0, e_cnt, 8'h00}, `RSX_RESP_OKAY);
        axi_rd(`RSX_OFF_WORK, {24'h0, e_w}, `RSX_RESP_OKAY);
        $display("test status done");
        wrap_up();
    end
endmodule

`default_nettype wire

// ===== rsx_cfg.svh
// Register offsets, field positions and reset values of the execution datapath
`ifndef RSX_CFG_SVH
`define RSX_CFG_SVH

`define RSX_OFF_CTRL      12'h000
`define RSX_OFF_WORK      12'h004
`define RSX_OFF_FLAGS     12'h008
`define RSX_OFF_STAT      12'h00c

`define RSX_CTRL_EN_BIT   0
`define RSX_CTRL_RESET    32'h0000_0001

`define RSX_FLAG_C_BIT    0
`define RSX_FLAG_AC_BIT   1
`define RSX_FLAG_Z_BIT    2
`define RSX_FLAG_OV_BIT   3
`define RSX_FLAG_GIE_BIT  4

`define RSX_STAT_DUMMY_BIT 0
`define RSX_STAT_CNT_LSB   8
`define RSX_STAT_CNT_MSB   15

`define RSX_WORK_RESET    8'h00
`define RSX_BYTE_ONES     8'hff
`define RSX_RESP_OKAY     2'b00
`define RSX_RESP_DECERR   2'b11

`endif

// ===== rsx_exec.sv
// Execution datapath for returns, rotates, subtracts, byte/bit set and skips
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`include "rsx_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module rsx_exec
    import rsx_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Instruction sequencer side
    input  wire logic        req_valid,
    input  wire exec_req_s   req,
    output logic             req_ready,
    input  wire logic        irq_pending,
    output logic             stack_pop,
    output logic             irq_enter,
    output logic             skip_next,
    output mem_wr_s          mem_wr,
    output byte_t            working_register,
    output flags_s           flags,
    output logic             global_irq_enable,
    // AXI4-Lite register slave
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    typedef enum logic {st_exec, st_dummy} exec_st_e;

    // Eight-bit subtract a - b - (not cin); carry high means no borrow
    function automatic alu_s sub8(input byte_t a, input byte_t b, input logic cin);
        logic [8:0] full;
        logic [4:0] low;
        alu_s       o;
        full    = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
        low     = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
        o.res   = full[7:0];
        o.f.c   = full[8];
        o.f.ac  = low[4];
        o.f.z   = (full[7:0] == 8'h00);
        o.f.ov  = (a[7] != b[7]) && (full[7] != a[7]);
        return o;
    endfunction

    function automatic logic is_reg(input logic [11:0] addr, input logic [11:0] off);
        return addr == off;
    endfunction

    exec_st_e    st_r;
    logic        ready_r;
    logic        ctrl_en_r;
    byte_t       work_r;
    flags_s      flags_r;
    logic        gie_r;
    logic        pop_r;
    logic        irq_r;
    logic        skip_r;
    mem_wr_s     wr_r;
    logic [7:0]  skip_cnt_r;

    logic [11:0] awaddr_r;
    logic        aw_held_r;
    logic        awready_r;
    logic        wready_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        w_held_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        arready_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    logic        fire;
    logic        sw_wr;
    byte_t       work_nxt;
    flags_s      flags_nxt;
    mem_wr_s     wr_nxt;
    logic        pop_nxt;
    logic        skip_nxt;
    logic        gie_set;
    alu_s        alu;
    byte_t       incdec;

    assign fire  = req_valid && ready_r;
    assign sw_wr = aw_held_r && w_held_r && !bvalid_r;

    // Operation decode
    always_comb begin
        work_nxt  = work_r;
        flags_nxt = flags_r;
        wr_nxt    = '{en: 1'b0, data: req.mem};
        pop_nxt   = 1'b0;
        skip_nxt  = 1'b0;
        gie_set   = 1'b0;
        alu       = sub8(work_r, req.mem, 1'b1);
        incdec    = req.mem;
        case (req.op)
            call_exit_load_literal: begin
                pop_nxt  = 1'b1;
                work_nxt = req.imm;
            end
            interrupt_exit: begin
                pop_nxt = 1'b1;
                gie_set = 1'b1;
            end
            rotate_left_mem: begin
                wr_nxt = '{en: 1'b1, data: {req.mem[6:0], req.mem[7]}};
            end
            rotate_left_to_working: begin
                work_nxt = {req.mem[6:0], req.mem[7]};
            end
            rotate_left_through_carry: begin
                wr_nxt      = '{en: 1'b1, data: {req.mem[6:0], flags_r.c}};
                flags_nxt.c = req.mem[7];
            end
            rotate_left_through_carry_to_working: begin
                work_nxt    = {req.mem[6:0], flags_r.c};
                flags_nxt.c = req.mem[7];
            end
            rotate_right_mem: begin
                wr_nxt = '{en: 1'b1, data: {req.mem[0], req.mem[7:1]}};
            end
            rotate_right_to_working: begin
                work_nxt = {req.mem[0], req.mem[7:1]};
            end
            rotate_right_through_carry: begin
                wr_nxt      = '{en: 1'b1, data: {flags_r.c, req.mem[7:1]}};
                flags_nxt.c = req.mem[0];
            end
            rotate_right_through_carry_to_working: begin
                work_nxt    = {flags_r.c, req.mem[7:1]};
                flags_nxt.c = req.mem[0];
            end
            minus_to_working: begin
                flags_nxt = alu.f;
                work_nxt  = alu.res;
            end
            minus_to_mem: begin
                flags_nxt = alu.f;
                wr_nxt    = '{en: 1'b1, data: alu.res};
            end
            minus_literal: begin
                alu       = sub8(work_r, req.imm, 1'b1);
                flags_nxt = alu.f;
                work_nxt  = alu.res;
            end
            minus_with_borrow_to_working: begin
                alu       = sub8(work_r, req.mem, flags_r.c);
                flags_nxt = alu.f;
                work_nxt  = alu.res;
            end
            minus_with_borrow_to_mem: begin
                alu       = sub8(work_r, req.mem, flags_r.c);
                flags_nxt = alu.f;
                wr_nxt    = '{en: 1'b1, data: alu.res};
            end
            decrement_skip_zero: begin
                incdec   = req.mem - 8'h01;
                wr_nxt   = '{en: 1'b1, data: incdec};
                skip_nxt = (incdec == 8'h00);
            end
            decrement_skip_zero_to_working: begin
                incdec   = req.mem - 8'h01;
                work_nxt = incdec;
                skip_nxt = (incdec == 8'h00);
            end
            increment_skip_zero: begin
                incdec   = req.mem + 8'h01;
                wr_nxt   = '{en: 1'b1, data: incdec};
                skip_nxt = (incdec == 8'h00);
            end
            increment_skip_zero_to_working: begin
                incdec   = req.mem + 8'h01;
                work_nxt = incdec;
                skip_nxt = (incdec == 8'h00);
            end
            fill_byte: begin
                wr_nxt = '{en: 1'b1, data: `RSX_BYTE_ONES};
            end
            bit_force: begin
                wr_nxt.en                = 1'b1;
                wr_nxt.data[req.bit_sel] = 1'b1;
            end
            skip_bit_nonzero: begin
                skip_nxt = req.mem[req.bit_sel];
            end
            default: begin
                work_nxt = work_r;
            end
        endcase
    end

    // Dummy cycle after a taken skip keeps the sequencer stalled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r    <= st_exec;
            ready_r <= 1'b0;
        end else begin
            case (st_r)
                st_exec: begin
                    if (fire && skip_nxt) begin
                        st_r    <= st_dummy;
                        ready_r <= 1'b0;
                    end else begin
                        ready_r <= ctrl_en_r;
                    end
                end
                st_dummy: begin
                    st_r    <= st_exec;
                    ready_r <= ctrl_en_r;
                end
                default: begin
                    st_r    <= st_exec;
                    ready_r <= 1'b0;
                end
            endcase
        end
    end

    // One-cycle strobes toward stack, memory and sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pop_r  <= 1'b0;
            irq_r  <= 1'b0;
            skip_r <= 1'b0;
            wr_r   <= '0;
        end else begin
            pop_r  <= fire && pop_nxt;
            irq_r  <= fire && (req.op == interrupt_exit) && irq_pending;
            skip_r <= fire && skip_nxt;
            wr_r   <= fire ? wr_nxt : '{en: 1'b0, data: wr_r.data};
        end
    end

    // Execution wins over a software write landing in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            work_r  <= `RSX_WORK_RESET;
            flags_r <= '0;
            gie_r   <= 1'b0;
        end else if (fire) begin
            work_r  <= work_nxt;
            flags_r <= flags_nxt;
            if (gie_set) begin
                gie_r <= 1'b1;
            end
        end else if (sw_wr && wstrb_r[0]) begin
            if (is_reg(awaddr_r, `RSX_OFF_WORK)) begin
                work_r <= wdata_r[7:0];
            end
            if (is_reg(awaddr_r, `RSX_OFF_FLAGS)) begin
                flags_r.c  <= wdata_r[`RSX_FLAG_C_BIT];
                flags_r.ac <= wdata_r[`RSX_FLAG_AC_BIT];
                flags_r.z  <= wdata_r[`RSX_FLAG_Z_BIT];
                flags_r.ov <= wdata_r[`RSX_FLAG_OV_BIT];
                gie_r      <= wdata_r[`RSX_FLAG_GIE_BIT];
            end
        end
    end

    // Wraps at 255; for software progress checks only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            skip_cnt_r <= 8'h00;
        end else if (fire && skip_nxt) begin
            skip_cnt_r <= skip_cnt_r + 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_en_r <= 1'(`RSX_CTRL_RESET);
        end else if (sw_wr && wstrb_r[0] && is_reg(awaddr_r, `RSX_OFF_CTRL)) begin
            ctrl_en_r <= wdata_r[`RSX_CTRL_EN_BIT];
        end
    end

    // AXI write: address and data latched independently, then answered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            awaddr_r  <= 12'h000;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `RSX_RESP_OKAY;
        end else begin
            // Ready is a flop, so it stays low for one edge after a release
            if (s_axi_awvalid && awready_r) begin
                aw_held_r <= 1'b1;
                awready_r <= 1'b0;
                awaddr_r  <= s_axi_awaddr;
            end else if (!aw_held_r) begin
                awready_r <= 1'b1;
            end
            if (s_axi_wvalid && wready_r) begin
                w_held_r <= 1'b1;
                wready_r <= 1'b0;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end else if (!w_held_r) begin
                wready_r <= 1'b1;
            end
            if (sw_wr) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= (is_reg(awaddr_r, `RSX_OFF_CTRL)
                             || is_reg(awaddr_r, `RSX_OFF_WORK)
                             || is_reg(awaddr_r, `RSX_OFF_FLAGS)
                             || is_reg(awaddr_r, `RSX_OFF_STAT))
                             ? `RSX_RESP_OKAY : `RSX_RESP_DECERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // AXI read: one outstanding, answer one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `RSX_RESP_OKAY;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rresp_r   <= `RSX_RESP_OKAY;
            rdata_r   <= 32'h0000_0000;
            if (is_reg(s_axi_araddr, `RSX_OFF_CTRL)) begin
                rdata_r[`RSX_CTRL_EN_BIT] <= ctrl_en_r;
            end else if (is_reg(s_axi_araddr, `RSX_OFF_WORK)) begin
                rdata_r[7:0] <= work_r;
            end else if (is_reg(s_axi_araddr, `RSX_OFF_FLAGS)) begin
                rdata_r[`RSX_FLAG_C_BIT]   <= flags_r.c;
                rdata_r[`RSX_FLAG_AC_BIT]  <= flags_r.ac;
                rdata_r[`RSX_FLAG_Z_BIT]   <= flags_r.z;
                rdata_r[`RSX_FLAG_OV_BIT]  <= flags_r.ov;
                rdata_r[`RSX_FLAG_GIE_BIT] <= gie_r;
            end else if (is_reg(s_axi_araddr, `RSX_OFF_STAT)) begin
                rdata_r[`RSX_STAT_DUMMY_BIT] <= (st_r == st_dummy);
                rdata_r[`RSX_STAT_CNT_MSB:`RSX_STAT_CNT_LSB] <= skip_cnt_r;
            end else begin
                rresp_r <= `RSX_RESP_DECERR;
            end
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
        end else if (!rvalid_r) begin
            arready_r <= 1'b1;
        end
    end

    assign req_ready         = ready_r;
    assign stack_pop         = pop_r;
    assign irq_enter         = irq_r;
    assign skip_next         = skip_r;
    assign mem_wr            = wr_r;
    assign working_register  = work_r;
    assign flags             = flags_r;
    assign global_irq_enable = gie_r;
    assign s_axi_awready     = awready_r;
    assign s_axi_wready      = wready_r;
    assign s_axi_bvalid      = bvalid_r;
    assign s_axi_bresp       = bresp_r;
    assign s_axi_arready     = arready_r;
    assign s_axi_rvalid      = rvalid_r;
    assign s_axi_rdata       = rdata_r;
    assign s_axi_rresp       = rresp_r;

endmodule

`default_nettype wire

// ===== rsx_exec_asserts.sv
// Concurrent checks on the execution datapath ports
`timescale 1ns/1ps
`default_nettype none

module rsx_exec_asserts
    import rsx_pkg::*;
(
    input wire logic      aclk,
    input wire logic      aresetn,
    input wire logic      req_valid,
    input wire exec_req_s req,
    input wire logic      req_ready,
    input wire logic      irq_pending,
    input wire logic      stack_pop,
    input wire logic      irq_enter,
    input wire logic      skip_next,
    input wire mem_wr_s   mem_wr,
    input wire byte_t     working_register,
    input wire flags_s    flags,
    input wire logic      global_irq_enable
);
    logic take;
    assign take = req_valid && req_ready;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_literal_load: assert property (
        take && req.op == call_exit_load_literal |=> stack_pop
        && working_register == $past(req.imm) && flags == $past(flags))
        else $error("literal return wrong");
    a_exit_gie: assert property (
        take && req.op == interrupt_exit |=> stack_pop && global_irq_enable)
        else $error("interrupt exit wrong");
    a_exit_pending: assert property (
        take && req.op == interrupt_exit && irq_pending |=> irq_enter)
        else $error("pending interrupt not entered");
    a_rotate_left: assert property (
        take && req.op == rotate_left_mem |=> mem_wr.en
        && mem_wr.data == {$past(req.mem[6:0]), $past(req.mem[7])})
        else $error("rotate left wrong");
    a_minus_carry: assert property (
        take && req.op == minus_literal |=> flags.c == ($past(working_register) >= $past(req.imm))
        && working_register == byte_t'($past(working_register) - $past(req.imm)))
        else $error("literal subtract wrong");
    a_dec_skip: assert property (
        take && req.op == decrement_skip_zero |=> skip_next == ($past(req.mem) == 8'h01))
        else $error("decrement skip wrong");
    a_skip_dummy: assert property (
        skip_next |-> !req_ready ##1 req_ready)
        else $error("dummy cycle wrong");
    a_fill_ones: assert property (
        take && req.op == fill_byte |=> mem_wr.en && mem_wr.data == 8'hff
        && flags == $past(flags))
        else $error("byte fill wrong");
    a_bit_force: assert property (
        take && req.op == bit_force |=> mem_wr.en
        && mem_wr.data == ($past(req.mem) | (8'h01 << $past(req.bit_sel))))
        else $error("bit force wrong");
    a_bit_skip: assert property (
        take && req.op == skip_bit_nonzero |=> skip_next == $past(req.mem[req.bit_sel]))
        else $error("bit test skip wrong");
endmodule

bind rsx_exec rsx_exec_asserts u_rsx_exec_asserts (.aclk, .aresetn, .req_valid, .req,
    .req_ready, .irq_pending, .stack_pop, .irq_enter, .skip_next, .mem_wr,
    .working_register, .flags, .global_irq_enable);

`default_nettype wire

// ===== rsx_pkg.sv
// Types shared by the rotate, subtract and skip execution datapath
package rsx_pkg;

    typedef logic [7:0] byte_t;

    typedef enum logic [4:0] {
        op_none,
        call_exit_load_literal,
        interrupt_exit,
        rotate_left_mem,
        rotate_left_to_working,
        rotate_left_through_carry,
        rotate_left_through_carry_to_working,
        rotate_right_mem,
        rotate_right_to_working,
        rotate_right_through_carry,
        rotate_right_through_carry_to_working,
        minus_to_working,
        minus_to_mem,
        minus_literal,
        minus_with_borrow_to_working,
        minus_with_borrow_to_mem,
        decrement_skip_zero,
        decrement_skip_zero_to_working,
        increment_skip_zero,
        increment_skip_zero_to_working,
        fill_byte,
        bit_force,
        skip_bit_nonzero
    } exec_op_e;

    typedef struct packed {
        exec_op_e    op;
        byte_t       mem;
        byte_t       imm;
        logic [2:0]  bit_sel;
    } exec_req_s;

    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
    } flags_s;

    typedef struct packed {
        logic  en;
        byte_t data;
    } mem_wr_s;

    typedef struct packed {
        byte_t  res;
        flags_s f;
    } alu_s;

endpackage

// ===== seq_model.sv
// Instruction sequencer stand-in feeding the execution datapath
`timescale 1ns/1ps
`default_nettype none

module seq_model
    import rsx_pkg::*;
(
    input  wire logic aclk,
    output exec_req_s req,
    output logic      req_valid,
    input  wire logic req_ready,
    output logic      irq_pending
);
    initial begin
        req_valid   = 1'b0;
        req         = '0;
        irq_pending = 1'b0;
    end

    // Holds the offer until taken; ok stays low if no take within the bound
    task automatic issue(input exec_req_s r, input logic irq, output logic ok);
        ok = 1'b0;
        req_valid   <= 1'b1;
        req         <= r;
        irq_pending <= irq;
        for (int i = 0; i < 20 && !ok; i++) begin
            @(posedge aclk);
            ok = req_ready;
        end
        req_valid   <= 1'b0;
        // Released fields move, so a stale value is never mistaken for a request
        req         <= ~r;
        irq_pending <= ~irq;
    endtask
endmodule

`default_nettype wire
